//--- ccs_params.svh
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
// ***************************************************
// register file geometry
// ***************************************************
`define CCS_NUM_REGS      32
`define CCS_PTR_LO_BASE   5'h1A
`define CCS_PTR_X_LO      5'h1A
`define CCS_PTR_Y_LO      5'h1C
`define CCS_PTR_Z_LO      5'h1E
// ***************************************************
// data-space map
// ***************************************************
`define CCS_DS_REG_LAST   16'h001F
`define CCS_DS_IO_FIRST   16'h0020
`define CCS_DS_IO_LAST    16'h005F
`define CCS_DS_XIO_LAST   16'h00FF
`define CCS_IO_OFFSET     16'h0020
// ***************************************************
// i/o register offsets and resets
// ***************************************************
`define CCS_IO_SP_LOW     6'h3D
`define CCS_IO_SP_HIGH    6'h3E
`define CCS_IO_STATUS     6'h3F
`define CCS_SP_RESET      16'h0000
`define CCS_SP_HIGH_MASK  8'h07
`define CCS_STATUS_RESET  8'h00
// ***************************************************
// status flag bit positions
// ***************************************************
`define CCS_FLAG_I        7
`define CCS_FLAG_T        6
`define CCS_FLAG_H        5
`define CCS_FLAG_S        4
`define CCS_FLAG_V        3
`define CCS_FLAG_N        2
`define CCS_FLAG_Z        1
`define CCS_FLAG_C        0
// ***************************************************
// boot section start word address
// ***************************************************
`define CCS_BOOT_START    16'h1C00
`endif

//--- ccs_pkg.sv
// ***************************************************
// shared types for the core state block
// ***************************************************
package ccs_pkg;
	// stack operations
	typedef enum logic [2:0] {
		CCS_STK_NONE,
		CCS_STK_PUSH,
		CCS_STK_POP,
		CCS_STK_CALL,
		CCS_STK_RET,
		CCS_STK_IRQ,
		CCS_STK_RETURN_FROM_IRQ_INSTR
	} ccs_stk_op_t;
	// pointer addressing forms
	typedef enum logic [1:0] {
		CCS_PTR_DISP,
		CCS_PTR_POSTINC,
		CCS_PTR_PREDEC
	} ccs_ptr_mode_t;
	// global enable commands
	typedef enum logic [1:0] {
		CCS_GIE_KEEP,
		CCS_GIE_SET,
		CCS_GIE_CLEAR
	} ccs_gie_op_t;
	// alu flag update bundle
	typedef struct packed {
		logic       valid;
		logic [7:0] mask;
		logic       h;
		logic       v;
		logic       n;
		logic       z;
		logic       c;
	} ccs_flag_upd_t;
	// register write port
	typedef struct packed {
		logic       en;
		logic [4:0] idx;
		logic [7:0] data;
	} ccs_reg_wr_t;
	// data-space access request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ccs_ds_req_t;
	// pointer request
	typedef struct packed {
		logic          en;
		logic [1:0]    sel;
		ccs_ptr_mode_t mode;
		logic [5:0]    disp;
	} ccs_ptr_req_t;
endpackage : ccs_pkg

//--- ccs_core_state.sv
`include "ccs_params.svh"
// Functional notes
// RL1: fetch next instruction while current one executes
// RL2: 32 by 8-bit registers, single-cycle access
// RL3: top six registers form three pointers
// RL4: pointers support displacement, increment, decrement
// RL5: registers mapped at first 32 data addresses
// RL6: 64 i/o addresses, also at 0x20-0x5F
// RL7: extended i/o only via data-space access
// RL8: flags updated after every alu operation
// RL9: flags not saved or restored on interrupts
// RL10: bit 7 gates all interrupts globally
// RL11: enable cleared on entry, set by return
// RL12: bit 6 is bit-copy store
// RL13: bit 5 holds low-nibble half carry
// RL14: bit 4 equals negative xor overflow
// RL15: bit 3 holds two's complement overflow
// RL16: bits 2,1,0 are negative, zero, carry
// RL17: stack grows down, byte push/pop by one
// RL18: calls and returns move pointer by two
// RL19: stack pointer as two i/o bytes
// RL20: software sets stack pointer before use
// RL21: self-write to application only from boot
// RL22: lowest pending vector wins priority
// RL23: flag conditions follow instruction set semantics
module ccs_core_state (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// program fetch
	input  wire logic                 fetch_advance,
	input  wire logic [15:0]          fetch_addr,
	input  wire logic [15:0]          fetch_word,
	output logic      [15:0]          fetch_instr,
	output logic      [15:0]          fetch_instr_addr,
	// register file operand and result ports
	input  wire logic [4:0]           rd_idx_a,
	input  wire logic [4:0]           rd_idx_b,
	output logic      [7:0]           rd_data_a,
	output logic      [7:0]           rd_data_b,
	input  wire ccs_pkg::ccs_reg_wr_t reg_wr,
	input  wire logic                 bit_store_instr,
	input  wire logic                 bit_load_instr,
	input  wire logic [2:0]           copy_bit_sel,
	// pointer unit
	input  wire ccs_pkg::ccs_ptr_req_t ptr_req,
	output logic      [15:0]          ptr_addr,
	// data space and i/o access
	input  wire ccs_pkg::ccs_ds_req_t ds_req,
	input  wire logic                 io_direct,
	output logic      [7:0]           ds_rdata,
	output logic                      ds_refused,
	output logic                      sram_sel,
	output logic                      periph_sel,
	input  wire logic [7:0]           periph_rdata,
	// flags and stack
	input  wire ccs_pkg::ccs_flag_upd_t flag_upd,
	input  wire ccs_pkg::ccs_gie_op_t gie_op,
	input  wire ccs_pkg::ccs_stk_op_t stk_op,
	output logic      [7:0]           status_flags,
	output logic      [15:0]          stack_top_pointer,
	// interrupts and self-write
	input  wire logic [7:0]           irq_pending,
	output logic                      irq_take,
	output logic      [2:0]           irq_vector,
	input  wire logic                 flash_self_write_instr,
	input  wire logic [15:0]          self_write_target,
	output logic                      self_write_grant
);
	// ***************************************************
	// storage
	// ***************************************************
	logic [7:0]  regs_ff [`CCS_NUM_REGS];  // working registers
	logic [7:0]  status_ff;                // status flags
	logic [15:0] sp_ff;                    // stack top pointer
	logic [15:0] instr_ff;                 // prefetched word
	logic [15:0] instr_addr_ff;            // its address
	logic [7:0]  ds_rdata_ff;              // read data
	logic        refused_ff;               // illegal direct access
	logic [15:0] ptr_addr_ff;              // effective pointer address

	// ***************************************************
	// helper functions
	// ***************************************************
	// pointer value from register pair, low byte first
	function automatic logic [15:0] ptr_val(input logic [1:0] sel,
	                                        input logic [7:0] lo,
	                                        input logic [7:0] hi);
		ptr_val = {hi, lo};
	endfunction : ptr_val

	// index of a pointer's low byte
	function automatic logic [4:0] ptr_lo_idx(input logic [1:0] sel);
		ptr_lo_idx = 5'(`CCS_PTR_LO_BASE + {2'h0, sel, 1'b0}); // RL3
	endfunction : ptr_lo_idx

	// ***************************************************
	// address decode
	// ***************************************************
	logic [15:0] eff_addr;   // data-space address of access
	logic        hit_reg;    // register file window
	logic        hit_io;     // i/o window
	logic        hit_xio;    // extended i/o window
	logic [5:0]  io_idx;     // i/o register offset
	always_comb begin
		// direct i/o offsets are shifted into data space
		if (io_direct) begin
			eff_addr = 16'(ds_req.addr + `CCS_IO_OFFSET); // RL6
		end else begin
			eff_addr = ds_req.addr;
		end
		hit_reg = (eff_addr <= `CCS_DS_REG_LAST);                 // RL5
		hit_io  = (eff_addr >= `CCS_DS_IO_FIRST) && (eff_addr <= `CCS_DS_IO_LAST);
		hit_xio = (eff_addr > `CCS_DS_IO_LAST) && (eff_addr <= `CCS_DS_XIO_LAST);
		io_idx  = 6'(eff_addr - `CCS_IO_OFFSET);
	end

	logic acc;  // legal access this cycle
	// direct i/o instructions cannot reach past the 64 i/o slots
	assign acc = (ds_req.rd | ds_req.wr) &
	             ~(io_direct & (ds_req.addr > 16'h003F)); // RL7
	assign sram_sel   = acc & ~hit_reg & ~hit_io & ~hit_xio;
	assign periph_sel = acc & ((hit_io & (io_idx != `CCS_IO_SP_LOW) &
	                    (io_idx != `CCS_IO_SP_HIGH) & (io_idx != `CCS_IO_STATUS)) | hit_xio);

	// ***************************************************
	// instruction prefetch
	// ***************************************************
	// next word captured while current one executes
	always_ff @(posedge clock) begin
		if (rst) begin
			instr_ff      <= 16'h0000;
			instr_addr_ff <= 16'h0000;
		end else if (fetch_advance) begin
			instr_ff      <= fetch_word;  // RL1
			instr_addr_ff <= fetch_addr;
		end
	end
	assign fetch_instr      = instr_ff;
	assign fetch_instr_addr = instr_addr_ff;

	// ***************************************************
	// register file
	// ***************************************************
	// combinational read gives single-cycle read-modify-write
	assign rd_data_a = regs_ff[rd_idx_a]; // RL2
	assign rd_data_b = regs_ff[rd_idx_b]; // RL2

	logic [4:0] p_lo;   // low byte index of selected pointer
	logic [15:0] p_cur; // current pointer value
	logic [15:0] p_new; // updated pointer value
	assign p_lo  = ptr_lo_idx(ptr_req.sel);
	assign p_cur = ptr_val(ptr_req.sel, regs_ff[p_lo], regs_ff[5'(p_lo + 5'h01)]);
	always_comb begin
		// form selects effective address and write-back
		case (ptr_req.mode)
			ccs_pkg::CCS_PTR_POSTINC: begin
				p_new    = 16'(p_cur + 16'h0001); // RL4
				ptr_addr = p_cur;
			end
			ccs_pkg::CCS_PTR_PREDEC: begin
				p_new    = 16'(p_cur - 16'h0001); // RL4
				ptr_addr = p_new;
			end
			default: begin
				p_new    = p_cur;
				ptr_addr = 16'(p_cur + {10'h000, ptr_req.disp}); // RL4
			end
		endcase
	end

	// writes: alu result, bit load, data-space store, pointer update
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < `CCS_NUM_REGS; i++) begin
				regs_ff[i] <= 8'h00;
			end
		end else begin
			if (reg_wr.en) begin
				regs_ff[reg_wr.idx] <= reg_wr.data; // RL2
			end
			if (bit_load_instr) begin
				regs_ff[reg_wr.idx][copy_bit_sel] <= status_ff[`CCS_FLAG_T]; // RL12
			end
			if (acc & ds_req.wr & hit_reg) begin
				regs_ff[eff_addr[4:0]] <= ds_req.wdata; // RL5
			end
			// pointer update wins over other writes to its pair
			if (ptr_req.en && ptr_req.mode != ccs_pkg::CCS_PTR_DISP) begin
				regs_ff[p_lo]               <= p_new[7:0];  // RL4
				regs_ff[5'(p_lo + 5'h01)]   <= p_new[15:8];
			end
		end
	end

	// ***************************************************
	// interrupt arbitration
	// ***************************************************
	always_comb begin
		// lowest index is the lowest vector, highest priority
		irq_vector = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (irq_pending[i]) begin
				irq_vector = 3'(i); // RL22
			end
		end
	end
	assign irq_take = status_ff[`CCS_FLAG_I] & (|irq_pending); // RL10

	// ***************************************************
	// status flags
	// ***************************************************
	// flags are never stacked; software keeps them if needed
	always_ff @(posedge clock) begin
		if (rst) begin
			status_ff <= `CCS_STATUS_RESET;
		end else begin
			if (flag_upd.valid) begin
				// masked per instruction-set definition of each flag
				if (flag_upd.mask[`CCS_FLAG_H])
					status_ff[`CCS_FLAG_H] <= flag_upd.h; // RL13 RL23
				if (flag_upd.mask[`CCS_FLAG_V])
					status_ff[`CCS_FLAG_V] <= flag_upd.v; // RL15
				if (flag_upd.mask[`CCS_FLAG_N])
					status_ff[`CCS_FLAG_N] <= flag_upd.n; // RL16
				if (flag_upd.mask[`CCS_FLAG_Z])
					status_ff[`CCS_FLAG_Z] <= flag_upd.z; // RL16
				if (flag_upd.mask[`CCS_FLAG_C])
					status_ff[`CCS_FLAG_C] <= flag_upd.c; // RL16 RL8
				if (flag_upd.mask[`CCS_FLAG_S])
					status_ff[`CCS_FLAG_S] <= flag_upd.n ^ flag_upd.v; // RL14
			end
			if (bit_store_instr) begin
				status_ff[`CCS_FLAG_T] <= rd_data_a[copy_bit_sel]; // RL12
			end
			if (acc & ds_req.wr & hit_io & (io_idx == `CCS_IO_STATUS)) begin
				status_ff <= ds_req.wdata;
			end
			// entry and return touch only the enable bit
			if (stk_op == ccs_pkg::CCS_STK_IRQ || gie_op == ccs_pkg::CCS_GIE_CLEAR) begin
				status_ff[`CCS_FLAG_I] <= 1'b0; // RL11 RL9
			end else if (stk_op == ccs_pkg::CCS_STK_RETURN_FROM_IRQ_INSTR || gie_op == ccs_pkg::CCS_GIE_SET) begin
				status_ff[`CCS_FLAG_I] <= 1'b1; // RL11
			end
		end
	end
	assign status_flags = status_ff;

	// ***************************************************
	// stack pointer
	// ***************************************************
	// software must load it before calls; reset value is not usable
	always_ff @(posedge clock) begin
		if (rst) begin
			sp_ff <= `CCS_SP_RESET;
		end else begin
			case (stk_op)
				ccs_pkg::CCS_STK_PUSH: sp_ff <= 16'(sp_ff - 16'h0001); // RL17
				ccs_pkg::CCS_STK_POP:  sp_ff <= 16'(sp_ff + 16'h0001); // RL17
				ccs_pkg::CCS_STK_CALL,
				ccs_pkg::CCS_STK_IRQ:  sp_ff <= 16'(sp_ff - 16'h0002); // RL18
				ccs_pkg::CCS_STK_RET,
				ccs_pkg::CCS_STK_RETURN_FROM_IRQ_INSTR: sp_ff <= 16'(sp_ff + 16'h0002); // RL18
				default: begin
					// byte writes through the i/o window
					if (acc & ds_req.wr & hit_io & (io_idx == `CCS_IO_SP_LOW))
						sp_ff[7:0] <= ds_req.wdata; // RL19
					else if (acc & ds_req.wr & hit_io & (io_idx == `CCS_IO_SP_HIGH))
						sp_ff[15:8] <= ds_req.wdata & `CCS_SP_HIGH_MASK; // RL19
				end
			endcase
		end
	end
	assign stack_top_pointer = sp_ff;

	// ***************************************************
	// read data and self-write guard
	// ***************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			ds_rdata_ff <= 8'h00;
			refused_ff  <= 1'b0;
		end else begin
			refused_ff <= (ds_req.rd | ds_req.wr) & ~acc; // RL7
			if (acc & ds_req.rd) begin
				if (hit_reg)
					ds_rdata_ff <= regs_ff[eff_addr[4:0]];
				else if (hit_io && io_idx == `CCS_IO_SP_LOW)
					ds_rdata_ff <= sp_ff[7:0];
				else if (hit_io && io_idx == `CCS_IO_SP_HIGH)
					ds_rdata_ff <= sp_ff[15:8];
				else if (hit_io && io_idx == `CCS_IO_STATUS)
					ds_rdata_ff <= status_ff;
				else
					ds_rdata_ff <= periph_rdata;
			end
		end
	end
	assign ds_rdata   = ds_rdata_ff;
	assign ds_refused = refused_ff;
	// application writes allowed only from boot-resident code
	assign self_write_grant = flash_self_write_instr &
	                          ((self_write_target >= `CCS_BOOT_START) |
	                           (instr_addr_ff >= `CCS_BOOT_START)); // RL21
endmodule : ccs_core_state

//--- ccs_core_state_assertions.sv
// ***************************************************
// checker for the core state ports
// ***************************************************
module ccs_core_state_assertions (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   rst,
	// requests into the core
	input wire ccs_pkg::ccs_stk_op_t   stk_op,
	input wire ccs_pkg::ccs_gie_op_t   gie_op,
	input wire ccs_pkg::ccs_flag_upd_t flag_upd,
	input wire ccs_pkg::ccs_ds_req_t   ds_req,
	input wire logic                   io_direct,
	input wire logic [7:0]             irq_pending,
	// state seen at the outputs
	input wire logic [7:0]             status_flags,
	input wire logic [15:0]            stack_top_pointer,
	input wire logic                   irq_take,
	input wire logic [2:0]             irq_vector,
	input wire logic                   ds_refused
);
	logic [10:0] sp_w;     // implemented pointer bits only
	logic        sign_in;  // sign the update should leave
	logic [7:0]  low_mask; // vectors ahead of the chosen one
	assign sp_w = stack_top_pointer[10:0];
	assign sign_in = flag_upd.n ^ flag_upd.v;
	assign low_mask = (8'h01 << irq_vector) - 8'h01;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// stack arithmetic, one and two byte moves
	a_push_dec_one: assert property (stk_op == ccs_pkg::CCS_STK_PUSH
		|=> sp_w == $past(sp_w) - 11'h001) else $error("push step wrong");
	a_pop_inc_one: assert property (stk_op == ccs_pkg::CCS_STK_POP
		|=> sp_w == $past(sp_w) + 11'h001) else $error("pop step wrong");
	a_call_dec_two: assert property (stk_op inside {ccs_pkg::CCS_STK_CALL,
		ccs_pkg::CCS_STK_IRQ} |=> sp_w == $past(sp_w) - 11'h002) else $error("call step wrong");
	a_ret_inc_two: assert property (stk_op inside {ccs_pkg::CCS_STK_RET,
		ccs_pkg::CCS_STK_RETURN_FROM_IRQ_INSTR} |=> sp_w == $past(sp_w) + 11'h002) else $error("ret step wrong");
	// global enable handling and vector priority
	a_irq_clears_gie: assert property (stk_op == ccs_pkg::CCS_STK_IRQ
		|=> !status_flags[7]) else $error("enable kept on entry");
	a_return_from_irq_instr_sets_gie: assert property (stk_op == ccs_pkg::CCS_STK_RETURN_FROM_IRQ_INSTR && !ds_req.wr
		&& gie_op == ccs_pkg::CCS_GIE_KEEP |=> status_flags[7]) else $error("enable not set");
	a_gie_gates_irq: assert property (irq_take == (status_flags[7]
		&& irq_pending != 8'h00)) else $error("take not gated by enable");
	a_vector_lowest: assert property (irq_take |-> irq_pending[irq_vector]
		&& (irq_pending & low_mask) == 8'h00) else $error("wrong vector chosen");
	// flag and access outcomes
	a_sign_is_xor: assert property (flag_upd.valid && flag_upd.mask[4] && !ds_req.wr
		|=> status_flags[4] == $past(sign_in)) else $error("sign not n xor v");
	a_refuse_high_io: assert property (ds_req.rd && io_direct
		&& ds_req.addr > 16'h003F |=> ds_refused) else $error("bad offset not refused");
	// main scenarios reached
	c_irq_entry: cover property (stk_op == ccs_pkg::CCS_STK_IRQ);
	c_irq_taken: cover property (irq_take);
	c_refused: cover property (ds_refused);
endmodule : ccs_core_state_assertions

//--- ccs_mem_model.sv
// ***************************************************
// program flash and peripheral data model
// ***************************************************
module ccs_mem_model (
	// clock
	input wire logic  clock,
	// flash side
	input wire logic [15:0] fetch_addr,
	output logic     [15:0] fetch_word,
	// peripheral data side
	input wire logic  periph_sel,
	output logic [7:0] periph_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle_ff = 1'b0; // toggles so a released bus never looks stable
	// flash image is a fixed scramble of the word address
	assign fetch_word = fetch_addr ^ 16'hA55A;
	// idle pattern flips every cycle
	always_ff @(posedge clock) begin
		idle_ff <= ~idle_ff;
	end
	// drive data only while selected
	assign periph_rdata = periph_sel ? 8'hC3 : {4{idle_ff, ~idle_ff}};
endmodule : ccs_mem_model

//--- cpu_core_state_and_stack_tb_top.sv
// ***************************************************
// testbench for the core state block
// ***************************************************
module cpu_core_state_and_stack_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst = 1'b1, fetch_advance = 1'b0, bit_store_instr = 1'b0;
	logic bit_load_instr = 1'b0, io_direct = 1'b0, sw_instr = 1'b0;
	logic [15:0] sw_target = 16'h0000; // self-write target word
	logic [15:0] fetch_addr = 16'h0000, fetch_word, fetch_instr, fetch_instr_addr, ptr_addr;
	logic [15:0] stack_top_pointer, exp_sp;
	logic [4:0]  rd_idx_a = 5'h00, rd_idx_b = 5'h00;
	logic [7:0]  rd_data_a, rd_data_b, ds_rdata, periph_rdata, status_flags, flg;
	logic [7:0]  irq_pending = 8'h00;
	logic [2:0]  copy_bit_sel = 3'h0, irq_vector;
	logic [1:0]  sel_seen;
	logic ds_refused, sram_sel, periph_sel, irq_take, self_write_grant;
	ccs_pkg::ccs_reg_wr_t   reg_wr = '0;
	ccs_pkg::ccs_ptr_req_t  ptr_req = '0;
	ccs_pkg::ccs_ds_req_t   ds_req = '0;
	ccs_pkg::ccs_flag_upd_t flag_upd = '0;
	ccs_pkg::ccs_gie_op_t   gie_op = ccs_pkg::CCS_GIE_KEEP;
	ccs_pkg::ccs_stk_op_t   stk_op = ccs_pkg::CCS_STK_NONE;
	ccs_pkg::ccs_stk_op_t   ops [6] = '{ccs_pkg::CCS_STK_PUSH, ccs_pkg::CCS_STK_CALL,
		ccs_pkg::CCS_STK_POP, ccs_pkg::CCS_STK_RET, ccs_pkg::CCS_STK_IRQ, ccs_pkg::CCS_STK_RETURN_FROM_IRQ_INSTR};
	int dl [6] = '{-1, -2, 1, 2, -2, 2}; // pointer move per op
	logic [12:0] rows [4] = '{{5'h00, 8'h5A}, {5'h1F, 8'hA5}, {5'h10, 8'hFF}, {5'h1A, 8'h01}};
	int errors = 0, tests_run = 0, cycles = 0;
	always #5 clock = ~clock;
	// self-write guard driven from the bench
	ccs_core_state dut (.clock(clock), .rst(rst), .fetch_advance(fetch_advance),
		.fetch_addr(fetch_addr), .fetch_word(fetch_word), .fetch_instr(fetch_instr),
		.fetch_instr_addr(fetch_instr_addr), .rd_idx_a(rd_idx_a), .rd_idx_b(rd_idx_b),
		.rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .reg_wr(reg_wr),
		.bit_store_instr(bit_store_instr), .bit_load_instr(bit_load_instr),
		.copy_bit_sel(copy_bit_sel), .ptr_req(ptr_req), .ptr_addr(ptr_addr), .ds_req(ds_req),
		.io_direct(io_direct), .ds_rdata(ds_rdata), .ds_refused(ds_refused),
		.sram_sel(sram_sel), .periph_sel(periph_sel), .periph_rdata(periph_rdata),
		.flag_upd(flag_upd), .gie_op(gie_op), .stk_op(stk_op), .status_flags(status_flags),
		.stack_top_pointer(stack_top_pointer), .irq_pending(irq_pending), .irq_take(irq_take),
		.irq_vector(irq_vector), .flash_self_write_instr(sw_instr),
		.self_write_target(sw_target), .self_write_grant(self_write_grant));
	ccs_mem_model mem (.clock(clock), .fetch_addr(fetch_addr), .fetch_word(fetch_word),
		.periph_sel(periph_sel), .periph_rdata(periph_rdata));
	// ***************************************************
	// shared tasks
	// ***************************************************
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one data-space or direct i/o access, sel lines caught mid-cycle
	task automatic ds(input logic rd, input logic dir, input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		ds_req <= '{rd, ~rd, a, d};
		io_direct <= dir;
		@(negedge clock);
		sel_seen = {sram_sel, periph_sel};
		@(posedge clock);
		ds_req <= '0;
		io_direct <= 1'b0;
		@(negedge clock);
	endtask : ds
	task automatic ctl(input ccs_pkg::ccs_stk_op_t op, input ccs_pkg::ccs_gie_op_t g);
		@(posedge clock);
		stk_op <= op;
		gie_op <= g;
		@(posedge clock);
		stk_op <= ccs_pkg::CCS_STK_NONE;
		gie_op <= ccs_pkg::CCS_GIE_KEEP;
		@(negedge clock);
	endtask : ctl
	task automatic rw(input logic [4:0] i, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= '{1'b1, i, d};
		@(posedge clock);
		reg_wr <= '0;
		@(negedge clock);
	endtask : rw
	task automatic summarize();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// hang guard, generous for the short sequence
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			summarize();
		end
	end
	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk("status reset", status_flags, 16'h0000);
		chk("pointer reset", stack_top_pointer, 16'h0000);
		// table rows: write, read both ports, read through data space
		foreach (rows[i]) begin
			rw(rows[i][12:8], rows[i][7:0]);
			rd_idx_a <= rows[i][12:8];
			rd_idx_b <= rows[i][12:8];
			@(negedge clock);
			chk("read a", rd_data_a, rows[i][7:0]);
			chk("read b", rd_data_b, rows[i][7:0]);
			ds(1'b1, 1'b0, {11'h000, rows[i][12:8]}, 8'h00);
			chk("mapped reg", ds_rdata, rows[i][7:0]);
		end
		// fetch capture
		@(posedge clock);
		fetch_advance <= 1'b1;
		fetch_addr <= 16'h0123;
		@(posedge clock);
		fetch_advance <= 1'b0;
		@(negedge clock);
		chk("fetch word", fetch_instr, 16'h0123 ^ 16'hA55A);
		chk("fetch addr", fetch_instr_addr, 16'h0123);
		// flags through the mask, sign forced from n and v
		@(posedge clock);
		flag_upd <= '{1'b1, 8'h3F, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		@(posedge clock);
		flag_upd <= '{1'b1, 8'h1F, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
		@(negedge clock);
		chk("flags one", status_flags[5:0], 16'h0035);
		@(posedge clock);
		flag_upd <= '0;
		@(negedge clock);
		chk("flags two", status_flags[5:0], 16'h002E);
		// bit copy: store r0 bit0, then load into r16 bit7
		@(posedge clock);
		rd_idx_a <= 5'h00;
		bit_store_instr <= 1'b1;
		@(posedge clock);
		bit_store_instr <= 1'b0;
		bit_load_instr <= 1'b1;
		copy_bit_sel <= 3'h7;
		reg_wr <= '{1'b0, 5'h10, 8'h00};
		@(posedge clock);
		bit_load_instr <= 1'b0;
		rd_idx_a <= 5'h10;
		@(negedge clock);
		chk("bit copy", {status_flags[6], rd_data_a}, 16'h007F);
		// pointer pair r30/r31: displacement, post-inc, pre-dec
		rw(5'h1E, 8'h34);
		rw(5'h1F, 8'h12);
		rd_idx_a <= 5'h1E;
		ptr_req <= '{1'b1, 2'h2, ccs_pkg::CCS_PTR_DISP, 6'h05};
		@(negedge clock);
		chk("ptr disp", ptr_addr, 16'h1239);
		@(posedge clock);
		ptr_req <= '{1'b1, 2'h2, ccs_pkg::CCS_PTR_POSTINC, 6'h00};
		@(negedge clock);
		chk("ptr post", ptr_addr, 16'h1234);
		chk("ptr post low", rd_data_a, 16'h0034);
		@(posedge clock);
		ptr_req <= '{1'b1, 2'h2, ccs_pkg::CCS_PTR_PREDEC, 6'h00};
		@(negedge clock);
		chk("ptr pre", {rd_data_a, ptr_addr[7:0]}, 16'h3534);
		@(posedge clock);
		ptr_req <= '0;
		@(negedge clock);
		chk("ptr back", rd_data_a, 16'h0034);
		// software places the stack first; high byte keeps three bits
		ds(1'b0, 1'b0, 16'h005D, 8'hFF);
		ds(1'b0, 1'b0, 16'h005E, 8'hFF);
		ds(1'b1, 1'b1, 16'h003E, 8'h00);
		chk("sp high", ds_rdata, 16'h0007);
		chk("sp word", stack_top_pointer, 16'h07FF);
		ds(1'b1, 1'b1, 16'h0040, 8'h00);
		chk("refused", ds_refused, 16'h0001);
		ds(1'b1, 1'b0, 16'h0080, 8'h00);
		chk("ext io", {sel_seen, ds_rdata}, 16'h01C3);
		ds(1'b1, 1'b0, 16'h0100, 8'h00);
		chk("sram sel", sel_seen, 16'h0002);
		// stack op table with enable tracking
		ctl(ccs_pkg::CCS_STK_NONE, ccs_pkg::CCS_GIE_SET);
		flg = status_flags;
		exp_sp = 16'h07FF;
		foreach (ops[i]) begin
			ctl(ops[i], ccs_pkg::CCS_GIE_KEEP);
			exp_sp = exp_sp + 16'(dl[i]);
			chk("stack step", stack_top_pointer, exp_sp);
			chk("enable", status_flags[7], {15'h0000, ops[i] != ccs_pkg::CCS_STK_IRQ});
		end
		chk("flags kept", status_flags[6:0], flg[6:0]);
		// priority and global gating
		@(posedge clock);
		irq_pending <= 8'h68;
		@(negedge clock);
		chk("irq take", {irq_take, irq_vector}, 16'h000B);
		ctl(ccs_pkg::CCS_STK_NONE, ccs_pkg::CCS_GIE_CLEAR);
		chk("irq masked", irq_take, 16'h0000);
		// self-write from application code: only the boot section may be hit
		@(posedge clock);
		sw_instr <= 1'b1;
		sw_target <= 16'h0000;
		@(negedge clock);
		chk("sw app denied", self_write_grant, 16'h0000);
		@(posedge clock);
		sw_target <= 16'h1C00;
		@(negedge clock);
		chk("sw boot ok", self_write_grant, 16'h0001);
		@(posedge clock);
		sw_instr <= 1'b0;
		@(negedge clock);
		summarize();
	end
endmodule : cpu_core_state_and_stack_tb_top
bind ccs_core_state ccs_core_state_assertions u_chk (.clock(clock), .rst(rst),
	.stk_op(stk_op), .gie_op(gie_op), .flag_upd(flag_upd), .ds_req(ds_req),
	.io_direct(io_direct), .irq_pending(irq_pending), .status_flags(status_flags),
	.stack_top_pointer(stack_top_pointer), .irq_take(irq_take), .irq_vector(irq_vector),
	.ds_refused(ds_refused));
